// [verilog/timer_pkg.sv]
`default_nettype none
package timer_pkg;
  // controller clock
  localparam int unsigned CLK_PERIOD_NS    = 25;
  // time base: 10 ms finest step, 1 s and 1 min derived from it
  localparam int unsigned BASE_TICK_MS     = 10;
  localparam int unsigned BASE_TICK_CYCLES = BASE_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_SEC    = 1000 / BASE_TICK_MS;
  localparam int unsigned SEC_PER_MIN      = 60;

  localparam int unsigned CNT_W = 13;
  localparam int unsigned REF_W = 17;

  // time unit codes
  localparam logic [1:0] UNIT_SEC  = 2'h0;
  localparam logic [1:0] UNIT_MIN  = 2'h1;
  localparam logic [1:0] UNIT_HOUR = 2'h2;

  // largest delay in steps of the unit's resolution
  localparam logic [REF_W-1:0] MAX_STEPS_SEC   = 17'h0270f;
  localparam logic [REF_W-1:0] MAX_STEPS_OTHER = 17'h0176f;
  // a referenced value in seconds unit is counted in ms
  localparam logic [REF_W-1:0] REF_MS_MAX      = 17'h18696;
  localparam logic [REF_W-1:0] REF_MS_PER_STEP = 17'h0000a;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG    = 8'h00;
  localparam logic [7:0] OFS_ON_DELAY  = 8'h04;
  localparam logic [7:0] OFS_OFF_DELAY = 8'h08;
  localparam logic [7:0] OFS_RET_DELAY = 8'h0c;
  localparam logic [7:0] OFS_PLS_DELAY = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_ELAPSED_A = 8'h18;
  localparam logic [7:0] OFS_ELAPSED_B = 8'h1c;
  localparam logic [7:0] OFS_ELAPSED_C = 8'h20;

  // config field positions
  localparam int unsigned CFG_RETAIN_LSB = 0;
  localparam int unsigned CFG_UNIT_LSB   = 4;
  localparam int unsigned CFG_SRC_LSB    = 10;
  localparam int unsigned CFG_W          = 13;

  // values after reset
  localparam logic [CFG_W-1:0] CFG_RESET   = 13'h0000;
  localparam logic [CNT_W-1:0] DELAY_RESET = 13'h0064;
endpackage
`default_nettype wire

// [verilog/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_divider
  import timer_pkg::*;
#(
  parameter int unsigned COUNT = 100,
  parameter int unsigned WIDTH = $clog2(COUNT + 1)
)(
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic step_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } div_s;

  localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT - 1);

  div_s s;
  div_s next_s;

  assign tick_o = step_i && (s.cnt == LAST);

  always_comb
  begin
    next_s = s;
    if (step_i)
    begin
      next_s.cnt = (s.cnt == LAST) ? '0 : s.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// [verilog/delay_and_pulse_timers.sv]
// How it works
// R01: rising launch starts elapsed count toward on-delay
// R02: output goes high after launch stays high the whole on-delay
// R03: launch falling early clears elapsed count, output stays low
// R04: falling launch starts elapsed count toward off-delay
// R05: output goes low after launch stays low the whole off-delay
// R06: launch rising early clears elapsed count, output stays high
// R07: on power return retentive channels keep state, others default
// R08: retentive timer starts on rising launch, sets output at delay
// R09: retentive timer ignores launch once running or expired
// R10: cancel high clears retentive output and elapsed count
// R11: pulse relay sets output and starts count on rising launch
// R12: pulse output ends when delay elapses though launch is high
// R13: delays come from registers or referenced live values, unit selectable
// R14: out-of-range referenced delay is clamped to nearest valid value; in seconds unit the code wraps steps at 8192, 9999 giving 1807
// R15: resolution is 10 ms, 1 s or 1 min per unit
// R16: pulse ends at once when launch falls before delay elapses
// R17: elapsed counters step once per tick of selected time base
`timescale 1ns/1ps
`default_nettype none
module delay_and_pulse_timers
  import timer_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BASE_TICK_CYCLES
)(
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             power_up_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  input  wire logic             launch_onoff_i,
  input  wire logic             launch_ret_i,
  input  wire logic             cancel_ret_i,
  input  wire logic             launch_pulse_i,
  input  wire logic [REF_W-1:0] ref_on_i,
  input  wire logic [REF_W-1:0] ref_off_i,
  input  wire logic [REF_W-1:0] ref_ret_i,
  input  wire logic [REF_W-1:0] ref_pulse_i,
  output logic                  out_onoff_o,
  output logic                  out_ret_o,
  output logic                  out_pulse_o,
  output logic      [CNT_W-1:0] elapsed_onoff_o,
  output logic      [CNT_W-1:0] elapsed_ret_o,
  output logic      [CNT_W-1:0] elapsed_pulse_o
);
  typedef enum logic [2:0] {
    RET_IDLE = 3'b001,
    RET_RUN  = 3'b010,
    RET_DONE = 3'b100
  } ret_e;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [CNT_W-1:0] on_delay;
    logic [CNT_W-1:0] off_delay;
    logic [CNT_W-1:0] ret_delay;
    logic [CNT_W-1:0] pls_delay;
    logic [31:0]      rdata;
    logic             on_q;
    logic [CNT_W-1:0] on_cnt;
    ret_e             ret_st;
    logic [CNT_W-1:0] ret_cnt;
    logic             ret_prev;
    logic             pls_q;
    logic [CNT_W-1:0] pls_cnt;
    logic             pls_prev;
  } state_s;

  state_s s;
  state_s next_s;

  logic tick_10ms;
  logic tick_sec;
  logic tick_min;

  // finest step first, coarser units counted from it
  tick_divider #(.COUNT(BASE_CYCLES)) u_div_base (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .step_i     (1'b1),
    .tick_o     (tick_10ms)
  );
  tick_divider #(.COUNT(TICKS_PER_SEC)) u_div_sec (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .step_i     (tick_10ms),
    .tick_o     (tick_sec)
  );
  tick_divider #(.COUNT(SEC_PER_MIN)) u_div_min (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .step_i     (tick_sec),
    .tick_o     (tick_min)
  );

  function automatic logic pick_tick(input logic [1:0] unit, input logic t10,
                                     input logic ts, input logic tm);
    logic t;
    t = t10;
    if (unit == UNIT_MIN)
      t = ts;
    else if (unit == UNIT_HOUR)
      t = tm;
    return t;
  endfunction

  // referenced values in the seconds unit arrive in ms
  function automatic logic [CNT_W-1:0] limit(input logic use_ref, input logic [1:0] unit,
                                              input logic [CNT_W-1:0] cfg,
                                              input logic [REF_W-1:0] refv);
    logic [REF_W-1:0] v;
    logic [REF_W-1:0] mx;
    v  = use_ref ? refv : {4'h0, cfg};
    mx = (unit == UNIT_MIN || unit == UNIT_HOUR) ? MAX_STEPS_OTHER : MAX_STEPS_SEC;
    if (use_ref && unit == UNIT_SEC)
    begin
      if (v > REF_MS_MAX)
        v = REF_MS_MAX;
      v = v / REF_MS_PER_STEP;
    end
    if (v > mx)
      v = mx;
    return v[CNT_W-1:0];
  endfunction

  logic [1:0]       unit_on;
  logic [1:0]       unit_ret;
  logic [1:0]       unit_pls;
  logic             tick_on;
  logic             tick_ret;
  logic             tick_pls;
  logic [CNT_W-1:0] on_lim;
  logic [CNT_W-1:0] off_lim;
  logic [CNT_W-1:0] ret_lim;
  logic [CNT_W-1:0] pls_lim;
  logic [CNT_W-1:0] onoff_lim;

  assign unit_on  = s.cfg[CFG_UNIT_LSB +: 2];
  assign unit_ret = s.cfg[CFG_UNIT_LSB+2 +: 2];
  assign unit_pls = s.cfg[CFG_UNIT_LSB+4 +: 2];
  assign tick_on  = pick_tick(unit_on, tick_10ms, tick_sec, tick_min); // R15 R17
  assign tick_ret = pick_tick(unit_ret, tick_10ms, tick_sec, tick_min); // R15 R17
  assign tick_pls = pick_tick(unit_pls, tick_10ms, tick_sec, tick_min); // R15 R17
  assign on_lim  = limit(s.cfg[CFG_SRC_LSB], unit_on, s.on_delay, ref_on_i); // R14
  assign off_lim = limit(s.cfg[CFG_SRC_LSB], unit_on, s.off_delay, ref_off_i); // R14
  assign ret_lim = limit(s.cfg[CFG_SRC_LSB+1], unit_ret, s.ret_delay, ref_ret_i); // R14
  assign pls_lim = limit(s.cfg[CFG_SRC_LSB+2], unit_pls, s.pls_delay, ref_pulse_i); // R14
  // low output waits on the on-delay, high output on the off-delay
  assign onoff_lim = s.on_q ? off_lim : on_lim;

  always_comb
  begin
    next_s = s;

    // register port, read data valid only in the next cycle
    next_s.rdata = '0;
    if (wr_i)
    begin
      unique case (addr_i)
        OFS_CONFIG:    next_s.cfg = wdata_i[CFG_W-1:0];
        OFS_ON_DELAY:  next_s.on_delay = wdata_i[CNT_W-1:0];
        OFS_OFF_DELAY: next_s.off_delay = wdata_i[CNT_W-1:0];
        OFS_RET_DELAY: next_s.ret_delay = wdata_i[CNT_W-1:0];
        OFS_PLS_DELAY: next_s.pls_delay = wdata_i[CNT_W-1:0];
        default:       next_s.rdata = '0;
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        OFS_CONFIG:    next_s.rdata = {19'h0, s.cfg};
        OFS_ON_DELAY:  next_s.rdata = {19'h0, s.on_delay};
        OFS_OFF_DELAY: next_s.rdata = {19'h0, s.off_delay};
        OFS_RET_DELAY: next_s.rdata = {19'h0, s.ret_delay};
        OFS_PLS_DELAY: next_s.rdata = {19'h0, s.pls_delay};
        OFS_STATUS:    next_s.rdata = {29'h0, s.pls_q, s.ret_st == RET_DONE, s.on_q};
        OFS_ELAPSED_A: next_s.rdata = {19'h0, s.on_cnt};
        OFS_ELAPSED_B: next_s.rdata = {19'h0, s.ret_cnt};
        OFS_ELAPSED_C: next_s.rdata = {19'h0, s.pls_cnt};
        default:       next_s.rdata = '0;
      endcase
    end

    // on/off delay: count only while input and output disagree
    if (launch_onoff_i == s.on_q)
    begin
      next_s.on_cnt = '0; // R03 R06
    end
    else if (s.on_cnt >= onoff_lim)
    begin
      next_s.on_q   = launch_onoff_i; // R02 R05
      next_s.on_cnt = '0;
    end
    else if (tick_on)
    begin
      next_s.on_cnt = s.on_cnt + 13'h1; // R01 R04 R17
    end

    // retentive on-delay
    next_s.ret_prev = launch_ret_i;
    if (cancel_ret_i)
    begin
      next_s.ret_st  = RET_IDLE; // R10
      next_s.ret_cnt = '0;
    end
    else
    begin
      unique case (s.ret_st)
        RET_IDLE:
          if (launch_ret_i && !s.ret_prev)
            next_s.ret_st = RET_RUN; // R08
        RET_RUN:
          if (s.ret_cnt >= ret_lim)
            next_s.ret_st = RET_DONE; // R08 R09
          else if (tick_ret)
            next_s.ret_cnt = s.ret_cnt + 13'h1; // R17
        RET_DONE:
          next_s.ret_st = RET_DONE; // R09
        default:
          next_s.ret_st = RET_IDLE;
      endcase
    end

    // pulse relay
    next_s.pls_prev = launch_pulse_i;
    if (launch_pulse_i && !s.pls_prev && !s.pls_q)
    begin
      next_s.pls_q   = 1'b1; // R11
      next_s.pls_cnt = '0;
    end
    else if (s.pls_q)
    begin
      if (!launch_pulse_i)
        next_s.pls_q = 1'b0; // R16
      else if (s.pls_cnt >= pls_lim)
        next_s.pls_q = 1'b0; // R12
      else if (tick_pls)
        next_s.pls_cnt = s.pls_cnt + 13'h1; // R17
    end

    // return from power loss: only retentive channels keep their state
    if (power_up_i)
    begin
      if (!s.cfg[CFG_RETAIN_LSB])
      begin
        next_s.on_q   = 1'b0; // R07
        next_s.on_cnt = '0;
      end
      if (!s.cfg[CFG_RETAIN_LSB+1])
      begin
        next_s.ret_st  = RET_IDLE; // R07
        next_s.ret_cnt = '0;
      end
      if (!s.cfg[CFG_RETAIN_LSB+2])
      begin
        next_s.pls_q   = 1'b0; // R07
        next_s.pls_cnt = '0;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      s           <= '0;
      s.cfg       <= CFG_RESET;
      s.on_delay  <= DELAY_RESET;
      s.off_delay <= DELAY_RESET;
      s.ret_delay <= DELAY_RESET;
      s.pls_delay <= DELAY_RESET;
      s.ret_st    <= RET_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata_o         = s.rdata;
  assign out_onoff_o     = s.on_q;
  assign out_ret_o       = (s.ret_st == RET_DONE);
  assign out_pulse_o     = s.pls_q;
  assign elapsed_onoff_o = s.on_cnt;
  assign elapsed_ret_o   = s.ret_cnt;
  assign elapsed_pulse_o = s.pls_cnt;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_onoff_rise_cause: assert property ($rose(s.on_q) |-> $past(launch_onoff_i)
    && $past(s.on_cnt) >= $past(on_lim)) else $error("on/off output rose early"); // R02
  a_onoff_fall_cause: assert property ($fell(s.on_q) && !$past(power_up_i) |->
    !$past(launch_onoff_i) && $past(s.on_cnt) >= $past(off_lim))
    else $error("on/off output fell early"); // R05
  a_onoff_cancel_clear: assert property (launch_onoff_i == s.on_q && !power_up_i
    |=> s.on_cnt == 13'h0 && s.on_q == $past(s.on_q)) else $error("count not cleared"); // R03
  a_onoff_step_one: assert property (launch_onoff_i != s.on_q && s.on_cnt < onoff_lim
    && tick_on && !power_up_i |=> s.on_cnt == $past(s.on_cnt) + 13'h1)
    else $error("on/off count did not step"); // R17
  a_ret_cancel_clear: assert property (cancel_ret_i |=> !out_ret_o && s.ret_cnt == 13'h0)
    else $error("cancel did not clear"); // R10
  a_ret_no_restart: assert property (s.ret_st == RET_RUN && !cancel_ret_i && !tick_ret
    && !power_up_i |=> s.ret_cnt == $past(s.ret_cnt)) else $error("retentive restarted"); // R09
  a_ret_sets_at_delay: assert property ($rose(out_ret_o) |-> $past(s.ret_cnt) >= $past(ret_lim))
    else $error("retentive output early"); // R08
  a_pulse_ends_fall: assert property (s.pls_q && !launch_pulse_i |=> !s.pls_q)
    else $error("pulse outlived launch"); // R16
  a_pulse_ends_delay: assert property (s.pls_q && s.pls_cnt >= pls_lim |=> !s.pls_q)
    else $error("pulse outlived delay"); // R12
  a_power_defaults: assert property (power_up_i && !s.cfg[CFG_RETAIN_LSB+2]
    |=> !s.pls_q && s.pls_cnt == 13'h0) else $error("non-retentive state kept"); // R07
endmodule
`default_nettype wire

// [bench/far_blocks.sv]
`timescale 1ns/1ps
`default_nettype none
module far_blocks
  import timer_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic [REF_W-1:0] value_i,
  output logic      [REF_W-1:0] ref_on_o,
  output logic      [REF_W-1:0] ref_off_o,
  output logic      [REF_W-1:0] ref_ret_o,
  output logic      [REF_W-1:0] ref_pulse_o
);
  // actual values of other blocks change once per scan
  always_ff @(posedge core_clk_i)
  begin
    ref_on_o    <= value_i;
    ref_off_o   <= value_i;
    ref_ret_o   <= value_i;
    ref_pulse_o <= value_i;
  end
endmodule
`default_nettype wire

// [bench/delay_and_pulse_timers_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module delay_and_pulse_timers_bench;
  import timer_pkg::*;
  localparam int BC = 4;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             power_up = 1'b0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic [31:0]      rdata;
  logic             la_oo = 1'b0;
  logic             la_rt = 1'b0;
  logic             cancel = 1'b0;
  logic             la_pl = 1'b0;
  logic [REF_W-1:0] val = '0;
  logic [REF_W-1:0] r_on, r_off, r_rt, r_pl;
  logic             o_oo, o_rt, o_pl;
  logic [CNT_W-1:0] e_oo, e_rt, e_pl;
  int               n_fail = 0;
  int               compares = 0;

  initial forever #12.5 clk = ~clk;

  far_blocks i_far_blocks (.core_clk_i(clk), .value_i(val), .ref_on_o(r_on),
    .ref_off_o(r_off), .ref_ret_o(r_rt), .ref_pulse_o(r_pl));

  delay_and_pulse_timers #(.BASE_CYCLES(BC)) i_delay_and_pulse_timers (
    .core_clk_i(clk), .rst_b_i(rst_b), .power_up_i(power_up), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .launch_onoff_i(la_oo), .launch_ret_i(la_rt), .cancel_ret_i(cancel),
    .launch_pulse_i(la_pl), .ref_on_i(r_on), .ref_off_i(r_off), .ref_ret_i(r_rt),
    .ref_pulse_i(r_pl), .out_onoff_o(o_oo), .out_ret_o(o_rt), .out_pulse_o(o_pl),
    .elapsed_onoff_o(e_oo), .elapsed_ret_o(e_rt), .elapsed_pulse_o(e_pl));

  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("read data", exp, rdata);
  endtask

  function automatic logic outv(input int ch);
    return ch == 0 ? o_oo : (ch == 1 ? o_rt : o_pl);
  endfunction

  // output must stay away from v for lo cycles and reach it by hi
  task automatic reach(input int ch, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (outv(ch) !== v && n < hi)
    begin
      @(posedge clk);
      #1 n++;
    end
    check("output level", {31'h0, v}, {31'h0, outv(ch)});
    check("settled too early", 32'h0, {31'h0, n < lo});
  endtask

  task automatic stay(input int ch, input logic v, input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1 check("output hold", {31'h0, v}, {31'h0, outv(ch)});
    end
  endtask

  task automatic t_regs;
    rd_reg(OFS_CONFIG, 32'h0);
    rd_reg(OFS_ON_DELAY, {19'h0, DELAY_RESET});
    rd_reg(8'h40, 32'h0);
    wr_reg(OFS_STATUS, 32'h7);
    rd_reg(OFS_STATUS, 32'h0);
  endtask

  task automatic t_onoff;
    wr_reg(OFS_ON_DELAY, 32'h3);
    wr_reg(OFS_OFF_DELAY, 32'h2);
    rd_reg(OFS_ON_DELAY, 32'h3);
    la_oo <= 1'b1;
    stay(0, 1'b0, BC * 2);
    la_oo <= 1'b0;
    stay(0, 1'b0, BC * 4);
    check("on/off elapsed", 32'h0, {19'h0, e_oo});
    la_oo <= 1'b1;
    reach(0, 1'b1, BC * 2, BC * 3 + 4);
    la_oo <= 1'b0;
    stay(0, 1'b1, BC - 1);
    la_oo <= 1'b1;
    stay(0, 1'b1, BC * 3);
    la_oo <= 1'b0;
    reach(0, 1'b0, BC, BC * 2 + 4);
  endtask

  task automatic t_pulse;
    wr_reg(OFS_PLS_DELAY, 32'h3);
    la_pl <= 1'b1;
    reach(2, 1'b1, 0, 3);
    reach(2, 1'b0, BC * 2, BC * 3 + 4);
    check("pulse elapsed", 32'h3, {19'h0, e_pl});
    la_pl <= 1'b0;
    stay(2, 1'b0, 2);
    la_pl <= 1'b1;
    reach(2, 1'b1, 0, 3);
    check("pulse elapsed", 32'h0, {19'h0, e_pl});
    la_pl <= 1'b0;
    reach(2, 1'b0, 0, 3);
  endtask

  // referenced value in ms truncates to 10 ms steps; minutes give 1 s steps
  // second tick runs free, so a delay of 2 lasts between one and two seconds
  task automatic t_ref_unit;
    val <= 17'h00023;
    wr_reg(OFS_CONFIG, 32'h1000);
    la_pl <= 1'b1;
    reach(2, 1'b1, 0, 3);
    reach(2, 1'b0, BC * 2, BC * 3 + 4);
    la_pl <= 1'b0;
    wr_reg(OFS_CONFIG, 32'h0100);
    wr_reg(OFS_PLS_DELAY, 32'h2);
    la_pl <= 1'b1;
    reach(2, 1'b1, 0, 3);
    reach(2, 1'b0, BC * 100, BC * 200 + 4);
    check("pulse elapsed", 32'h2, {19'h0, e_pl});
    la_pl <= 1'b0;
  endtask

  task automatic t_ret_power;
    wr_reg(OFS_CONFIG, 32'h2);
    wr_reg(OFS_RET_DELAY, 32'h3);
    la_rt <= 1'b1;
    stay(1, 1'b0, BC);
    la_rt <= 1'b0;
    stay(1, 1'b0, 2);
    la_rt <= 1'b1;
    reach(1, 1'b1, 0, BC * 2);
    check("retentive elapsed", 32'h3, {19'h0, e_rt});
    rd_reg(OFS_STATUS, 32'h2);
    la_oo <= 1'b1;
    reach(0, 1'b1, BC * 2, BC * 3 + 4);
    power_up <= 1'b1;
    @(posedge clk);
    power_up <= 1'b0;
    la_oo <= 1'b0;
    @(posedge clk);
    #1 check("plain output after power", 32'h0, {31'h0, o_oo});
    check("retained output", 32'h1, {31'h0, o_rt});
    check("retained elapsed", 32'h3, {19'h0, e_rt});
    cancel <= 1'b1;
    reach(1, 1'b0, 0, 3);
    check("cancelled elapsed", 32'h0, {19'h0, e_rt});
    cancel <= 1'b0;
  endtask

  initial
  begin
    #250000;
    n_fail++;
    conclude();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_onoff();
    t_pulse();
    t_ref_unit();
    t_ret_power();
    conclude();
  end
endmodule
`default_nettype wire
